// File: core/ucs_cmd_regs.sv
// command-addressed mode, endpoint and status registers with input fifo
`timescale 1ns/1ns

module ucs_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr    <= '0;
      rdPtr    <= '0;
      count    <= '0;
      inReady  <= 1'b0;
      outValid <= 1'b0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      count    <= next_count;
      inReady  <= next_count != (AW+1)'(DEPTH);
      outValid <= next_count != '0;
    end
  end
endmodule : ucs_fifo

// bank of sticky flags; an event in the cycle of its clear is kept, so a
// transaction that finishes while its status is being read still raises it
module ucs_flag_bank #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] setBits,
  input  wire logic [WIDTH-1:0] clrBits,
  output logic      [WIDTH-1:0] flags
);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~clrBits) | setBits;
    end
  end
endmodule : ucs_flag_bank

module ucs_cmd_regs
  import ucs_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  // processor command port
  input  ucs_word_t             cmdWord,
  input  wire logic             cmdValid,
  output logic                  cmdReady,
  output logic [7:0]            rdData,
  output logic                  rdValid,
  input  wire logic             rdReady,
  // serial engine side
  input  wire logic             enhancedMode,
  input  wire logic             busResetSeen,
  input  wire logic             sofSeen,
  input  wire logic             suspended,
  input  wire logic             vbusPresent,
  input  ucs_xfer_t             xfer,
  input  wire logic             xferDone,
  input  wire logic [15:0]      bufFull0,
  input  wire logic [15:0]      bufFull1,
  input  wire logic [15:0]      epStalled,
  input  wire logic [15:0]      epSetup,
  // device pins and configuration outputs
  output logic                  irqPin,
  output logic                  divided_clock_pin,
  output logic                  internalClockRun,
  output logic                  dplus_pullup_enable,
  output logic [1:0]            ep2IsoMode,
  output logic [7:0]            endpoint_setup_byte [16],
  output logic [3:0]            selectedEp
);

  ucs_word_t   popWord;
  logic        popValid;
  logic        popReady;
  logic        take;
  logic [7:0]  usb_mode_config_byte;
  logic [7:0]  clock_out_divider_byte;
  logic [7:0]  curCmd;
  logic [2:0]  byteIdx;
  logic [15:0] epFlag;
  logic [1:0]  evFlag;
  logic [7:0]  last_xfer_result [16];
  logic        suspPrev;
  logic        sofOnly;
  logic [3:0]  cdf;
  logic [7:0]  divCount;
  logic [7:0]  halfLimit;
  logic [3:0]  cmdEp;
  logic        epInRange;
  logic [7:0]  next_rdData;
  logic [15:0] clrEp;
  logic [1:0]  clrEv;
  logic [1:0]  setEv;
  logic        anyFlag;
  logic [15:0] setEp;
  logic        xferRaises;

  // reads wait in the fifo behind earlier writes so a reply never overtakes
  // the command it belongs to; an unclaimed reply stalls the fifo drain
  ucs_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .inData   (cmdWord),
    .inValid  (cmdValid),
    .inReady  (cmdReady),
    .outData  (popWord),
    .outValid (popValid),
    .outReady (popReady)
  );

  assign popReady = !rdValid || rdReady;
  assign take     = popValid && popReady;
  assign cmdEp    = curCmd[3:0];
  assign epInRange = enhancedMode || (cmdEp <= DEFAULT_EP_LIMIT);
  assign sofOnly  = clock_out_divider_byte[DB_SOF_ONLY];
  assign cdf      = clock_out_divider_byte[3:0];

  // command and byte index tracking
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      curCmd     <= 8'h00_00;
      byteIdx    <= 3'd0;
      selectedEp <= 4'h0;
    end else if (take) begin
      if (popWord.kind == WK_CMD) begin
        curCmd  <= popWord.data;
        byteIdx <= 3'd0;
        if (popWord.data[7:4] == GRP_SELECT &&
            (enhancedMode || popWord.data[3:0] <= DEFAULT_EP_LIMIT)) begin
          selectedEp <= popWord.data[3:0];
        end
      end else if (byteIdx != 3'd7) begin
        byteIdx <= byteIdx + 3'd1;
      end
    end
  end

  // mode bytes: only the device reset restores them, bus reset is ignored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      usb_mode_config_byte   <= MODE_RESET;
      clock_out_divider_byte <= DIV_RESET;
    end else if (take && popWord.kind == WK_WDATA &&
                 curCmd == CMD_SET_MODE) begin
      if (byteIdx == 3'd0) begin
        usb_mode_config_byte <= popWord.data;
      end else if (byteIdx == 3'd1) begin
        clock_out_divider_byte <= popWord.data;
      end
    end
  end

  // per-endpoint configuration, enhanced mode only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        endpoint_setup_byte[i] <= 8'h00_00;
      end
    end else if (take && popWord.kind == WK_WDATA && enhancedMode &&
                 curCmd[7:4] == GRP_EP_CONFIG && byteIdx == 3'd0) begin
      endpoint_setup_byte[cmdEp] <= {1'b0, popWord.data[6:0]};
    end
  end

  // read side effects: which flags a reply clears
  always_comb begin
    clrEp = 16'h0000;
    clrEv = 2'b00;
    if (take && popWord.kind == WK_RDREQ) begin
      if (curCmd[7:4] == GRP_LAST_STATUS && epInRange && byteIdx == 3'd0) begin
        clrEp[cmdEp] = 1'b1;
      end
      if (curCmd == CMD_READ_IRQ && byteIdx == 3'd0) begin
        clrEv = 2'b11;
      end
    end
  end

  // nak and error results stay silent unless interrupt mode allows them
  assign xferRaises = (xfer.success && xfer.err != ERR_NAKED) ||
                      usb_mode_config_byte[MB_INT_MODE];

  always_comb begin
    setEp = 16'h0000;
    if (xferDone && xferRaises) begin
      setEp[xfer.ep] = 1'b1;
    end
  end

  // previous suspend level idles low like the input, so reset makes no edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      suspPrev <= 1'b0;
    end else begin
      suspPrev <= suspended;
    end
  end

  assign setEv = {suspended != suspPrev, busResetSeen};

  // set wins over a clear landing in the same cycle
  ucs_flag_bank #(
    .WIDTH (16)
  ) u_ep_flags (
    .clk     (clk),
    .rst_n   (rst_n),
    .setBits (setEp),
    .clrBits (clrEp),
    .flags   (epFlag)
  );

  ucs_flag_bank #(
    .WIDTH (2)
  ) u_ev_flags (
    .clk     (clk),
    .rst_n   (rst_n),
    .setBits (setEv),
    .clrBits (clrEv),
    .flags   (evFlag)
  );

  // last transaction status per endpoint
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        last_xfer_result[i] <= 8'h00_00;
      end
    end else begin
      if (clrEp != 16'h0000) begin
        last_xfer_result[cmdEp][7] <= 1'b0;
      end
      if (xferDone) begin
        last_xfer_result[xfer.ep] <= {
          epFlag[xfer.ep] || last_xfer_result[xfer.ep][7],
          xfer.toggle, xfer.setup, xfer.err, xfer.success};
      end
    end
  end

  // reply byte for the current command and byte position
  always_comb begin
    next_rdData = 8'h00_00;
    if (curCmd == CMD_READ_IRQ) begin
      case (byteIdx)
        3'd0:    next_rdData = {evFlag[1], evFlag[0], epFlag[5:0]};
        3'd2:    next_rdData = enhancedMode ? epFlag[13:6] : 8'h00_00;
        3'd3:    next_rdData = enhancedMode ?
                               {6'b000000, epFlag[15:14]} : 8'h00_00;
        default: next_rdData = 8'h00_00;
      endcase
    end else if (epInRange && byteIdx == 3'd0) begin
      case (curCmd[7:4])
        GRP_SELECT:      next_rdData = {6'b000000, epStalled[cmdEp],
                                        bufFull0[cmdEp] | bufFull1[cmdEp]};
        GRP_LAST_STATUS: next_rdData = last_xfer_result[cmdEp];
        GRP_EP_STATUS:   next_rdData = {epStalled[cmdEp], bufFull1[cmdEp],
                                        bufFull0[cmdEp], 2'b00,
                                        epSetup[cmdEp], 2'b00};
        default:         next_rdData = 8'h00_00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdValid <= 1'b0;
      rdData  <= 8'h00_00;
    end else if (take && popWord.kind == WK_RDREQ) begin
      rdValid <= 1'b1;
      rdData  <= next_rdData;
    end else if (rdReady) begin
      rdValid <= 1'b0;
    end
  end

  assign anyFlag = (epFlag != 16'h0000) || (evFlag != 2'b00);

  // interrupt pin: sof pulses only, or any pending flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqPin <= 1'b0;
    end else if (sofOnly) begin
      irqPin <= sofSeen;
    end else begin
      irqPin <= anyFlag;
    end
  end

  // clock pin is a scaled model: base is the 10 MHz clock, not 48 MHz
  assign halfLimit = (suspended && !usb_mode_config_byte[MB_NO_SUSP_CLK]) ?
                     SUSP_HALF_CYCLES : {4'h0, cdf};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divCount          <= 8'h00_00;
      divided_clock_pin <= 1'b0;
    end else if (cdf == CDF_OFF) begin
      divCount          <= 8'h00_00;
      divided_clock_pin <= 1'b0;
    end else if (divCount >= halfLimit) begin
      divCount          <= 8'h00_00;
      divided_clock_pin <= !divided_clock_pin;
    end else begin
      divCount <= divCount + 8'h00_01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      internalClockRun    <= 1'b1;
      dplus_pullup_enable <= 1'b0;
      ep2IsoMode          <= 2'b00;
    end else begin
      internalClockRun    <= !suspended ||
                             usb_mode_config_byte[MB_CLK_RUN];
      dplus_pullup_enable <= usb_mode_config_byte[MB_PULLUP] &&
                             vbusPresent;
      ep2IsoMode          <= enhancedMode ? 2'b00 :
                             usb_mode_config_byte[MB_EP2_LO +: 2];
    end
  end

endmodule : ucs_cmd_regs

// File: pkg/ucs_pkg.sv
// constants and carriers for the usb command and status register block
//
// Notes on behaviour
// - no-suspend-clock bit 1 low drops clock pin to 30 kHz in suspend; resets to 1
// - mode bit 2 low stops internal clocks during suspend; resets to 1
// - mode bit 3 high lets nak and error transactions raise interrupts
// - mode bit 4 enables d+ pull-up only while bus power is present
// - usb bus reset leaves all mode and divider settings untouched
// - default mode: mode bits 7-6 pick endpoint 2 iso mode; ignored enhanced
// - divide factor resets 0xB; clock is base over 2(factor+1); 0xF turns it off
// - divider byte bit 7 high: interrupt only on start-of-frame reception
// - enhanced mode commands 0xB0-0xBF set enable, type, max packet size
// - read-interrupt 0xF4 returns 1-2 bytes default, 1-4 enhanced
// - endpoint flags set on buffer event, clear on last-status read
// - bus reset flag sets on bus reset, clears after interrupt byte read
// - suspend change flag sets entering or leaving suspend, clears on read
// - enhanced bytes 3 and 4 carry endpoints 3 to 7, out before in
// - select endpoint 0x00-0x05 or 0x00-0x0F; read gives full and stalled
// - last status 0x40-0x4F: success, error, setup, toggle, unread bits
// - four-bit error codes encode the listed transaction results
// - endpoint status 0x80-0x8F: setup bit 2, buffer full bits 5 and 6
// - endpoint status bit 7 reports the endpoint stalled
package ucs_pkg;

  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned SUSPEND_CLK_HZ  = 30_000;
  localparam logic [7:0]  SUSP_HALF_CYCLES =
    8'((CLK_HZ + 2 * SUSPEND_CLK_HZ - 1) / (2 * SUSPEND_CLK_HZ) - 1);

  localparam logic [7:0] CMD_SET_MODE     = 8'h00_F3;
  localparam logic [7:0] CMD_READ_IRQ     = 8'h00_F4;
  localparam logic [3:0] GRP_SELECT       = 4'h0;
  localparam logic [3:0] GRP_LAST_STATUS  = 4'h4;
  localparam logic [3:0] GRP_EP_STATUS    = 4'h8;
  localparam logic [3:0] GRP_EP_CONFIG    = 4'hB;
  localparam logic [3:0] DEFAULT_EP_LIMIT = 4'h5;

  // first mode byte fields and reset value
  localparam int unsigned MB_NO_SUSP_CLK = 1;
  localparam int unsigned MB_CLK_RUN     = 2;
  localparam int unsigned MB_INT_MODE    = 3;
  localparam int unsigned MB_PULLUP      = 4;
  localparam int unsigned MB_EP2_LO      = 6;
  localparam logic [7:0]  MODE_RESET     = 8'h00_0E;

  // divider byte fields and reset value
  localparam int unsigned DB_SOF_ONLY    = 7;
  localparam logic [7:0]  DIV_RESET      = 8'h00_0B;
  localparam logic [3:0]  CDF_OFF        = 4'hF;

  // interrupt byte 1 event bits
  localparam int unsigned IB_BUS_RESET   = 6;
  localparam int unsigned IB_SUSPEND     = 7;

  typedef enum logic [3:0] {
    ERR_NONE       = 4'b0000,
    ERR_PID_ENC    = 4'b0001,
    ERR_PID_UNK    = 4'b0010,
    ERR_UNEXP_PKT  = 4'b0011,
    ERR_TOKEN_CRC  = 4'b0100,
    ERR_DATA_CRC   = 4'b0101,
    ERR_TIMEOUT    = 4'b0110,
    ERR_UNEXP_EOP  = 4'b1000,
    ERR_NAKED      = 4'b1001,
    ERR_STALL_SENT = 4'b1010,
    ERR_OVERFLOW   = 4'b1011,
    ERR_BIT_STUFF  = 4'b1101,
    ERR_DATA_PID   = 4'b1111
  } ucs_err_t;

  typedef enum logic [1:0] {
    WK_CMD   = 2'b00,
    WK_WDATA = 2'b01,
    WK_RDREQ = 2'b10
  } ucs_kind_t;

  typedef struct packed {
    ucs_kind_t  kind;
    logic [7:0] data;
  } ucs_word_t;

  // one finished usb transaction reported by the serial engine
  typedef struct packed {
    logic [3:0] ep;
    logic       success;
    ucs_err_t   err;
    logic       setup;
    logic       toggle;
  } ucs_xfer_t;

  localparam int unsigned WORD_W     = $bits(ucs_word_t);
  localparam int unsigned FIFO_DEPTH = 32;

endpackage : ucs_pkg

// File: test/ucs_cmd_regs_checker.sv
// assertions on the command and status register ports
`timescale 1ns/1ns
module ucs_cmd_regs_checker
  import ucs_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire ucs_word_t  cmdWord,
  input wire logic       cmdValid,
  input wire logic       cmdReady,
  input wire logic [7:0] rdData,
  input wire logic       rdValid,
  input wire logic       rdReady,
  input wire logic       enhancedMode,
  input wire logic       suspended,
  input wire logic       vbusPresent,
  input wire logic       irqPin,
  input wire logic       internalClockRun,
  input wire logic       dplus_pullup_enable,
  input wire logic [1:0] ep2IsoMode,
  input wire logic [7:0] endpoint_setup_byte [16],
  input wire logic [3:0] selectedEp
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic cfgTop;
  always_comb begin
    cfgTop = 1'b0;
    foreach (endpoint_setup_byte[i])
      cfgTop = cfgTop | endpoint_setup_byte[i][7];
  end

  sequence rd_taken;
    cmdValid && cmdReady && cmdWord.kind == WK_RDREQ;
  endsequence
  sequence held_reply;
    rdValid && !rdReady;
  endsequence

  reset_vals_a: assert property ($rose(rst_n) |-> internalClockRun
    && !dplus_pullup_enable && !rdValid && !cmdReady && !irqPin)
    else $error("outputs not at reset values");
  reply_hold_a: assert property (held_reply |=> rdValid
    && $stable(rdData)) else $error("reply changed before accepted");
  reply_due_a: assert property (rd_taken |-> ##[1:40] rdValid)
    else $error("read request got no reply");
  pullup_vbus_a: assert property (!vbusPresent |=> !dplus_pullup_enable)
    else $error("pull-up on without bus power");
  clock_run_a: assert property (!suspended |=> internalClockRun)
    else $error("internal clock stopped while awake");
  ep2_enh_a: assert property (enhancedMode |=> ep2IsoMode == 2'b00)
    else $error("endpoint 2 mode set in enhanced mode");
  cfg_rsvd_a: assert property (!cfgTop)
    else $error("reserved endpoint setup bit set");
  sel_range_a: assert property ($changed(selectedEp)
    && !$past(enhancedMode) |-> selectedEp <= 4'h5)
    else $error("default mode selected a high endpoint");
endmodule : ucs_cmd_regs_checker

bind ucs_cmd_regs ucs_cmd_regs_checker chk (.*);

// File: test/ucs_host_model.sv
// usb host side stand-in driving bus events into the block
`timescale 1ns/1ns
module ucs_host_model
  import ucs_pkg::*;
(
  input  wire logic clk,
  output logic      busResetSeen,
  output logic      sofSeen,
  output logic      suspended,
  output ucs_xfer_t xfer,
  output logic      xferDone
);
  initial begin
    {busResetSeen, sofSeen, suspended, xferDone} = 4'h0;
    xfer = '1;
  end
  // the status word is only good in its cycle, so scramble it afterwards
  task automatic send(input ucs_xfer_t t);
    @(negedge clk);
    xfer <= t;
    xferDone <= 1'b1;
    @(negedge clk);
    xfer <= ~t;
    xferDone <= 1'b0;
  endtask : send
  task automatic bus_reset();
    @(negedge clk);
    busResetSeen <= 1'b1;
    @(negedge clk);
    busResetSeen <= 1'b0;
  endtask : bus_reset
  task automatic sof();
    @(negedge clk);
    sofSeen <= 1'b1;
    @(negedge clk);
    sofSeen <= 1'b0;
  endtask : sof
  task automatic set_susp(input logic s);
    @(negedge clk);
    suspended <= s;
  endtask : set_susp
endmodule : ucs_host_model

// File: test/usb_device_command_status_regs_bench.sv
// self-checking bench for the usb command and status registers
`timescale 1ns/1ns
module usb_device_command_status_regs_bench;
  import ucs_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  ucs_word_t   cmdWord = '0;
  logic        cmdValid = 1'b0;
  logic        rdReady = 1'b0;
  logic        enhancedMode = 1'b0;
  logic        vbusPresent = 1'b1;
  logic [15:0] bufFull0 = '0, bufFull1 = '0, epStalled = '0, epSetup = '0;
  logic        cmdReady, rdValid, irqPin, divided_clock_pin, suspended;
  logic        internalClockRun, dplus_pullup_enable, busResetSeen;
  logic        sofSeen, xferDone;
  logic [7:0]  rdData;
  logic [7:0]  endpoint_setup_byte [16];
  logic [1:0]  ep2IsoMode;
  logic [3:0]  selectedEp;
  ucs_xfer_t   xfer;
  logic [7:0]  expQ [$];
  int          fail_count = 0, checked = 0, cycles = 0;
  bit          rdRandom = 1'b1;

  always #50 clk = ~clk;
  ucs_cmd_regs uut (.*);
  ucs_host_model host (.*);

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic wrap_up();
    if (expQ.size() != 0)
      fail_count++;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  always @(posedge clk)
    if (rdValid === 1'b1 && rdReady === 1'b1)
      check_val(rdData, expQ.size() > 0 ? expQ.pop_front() : 8'hxx);
  // random stalls on the reply side exercise the hold of each reply
  always @(negedge clk)
    rdReady <= rdRandom ? 1'($urandom) : 1'b0;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10_000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic put(input ucs_kind_t k, input logic [7:0] d);
    @(negedge clk);
    cmdWord <= '{k, d};
    cmdValid <= 1'b1;
    do @(posedge clk); while (cmdReady !== 1'b1);
    @(negedge clk);
    cmdValid <= 1'b0;
  endtask : put
  task automatic cmd(input logic [7:0] c);
    put(WK_CMD, c);
  endtask : cmd
  task automatic rd(input logic [7:0] e);
    expQ.push_back(e);
    put(WK_RDREQ, 8'h00);
  endtask : rd
  task automatic set_mode(input logic [7:0] m, input logic [7:0] d);
    cmd(CMD_SET_MODE);
    put(WK_WDATA, m);
    put(WK_WDATA, d);
    repeat (4) @(negedge clk);
  endtask : set_mode
  task automatic drain();
    for (int i = 0; i < 300 && expQ.size() > 0; i++)
      @(posedge clk);
    @(negedge clk);
  endtask : drain
  // half period of the clock pin, counted between two of its changes
  task automatic half(input int e);
    logic p;
    int n;
    for (int r = 0; r < 2; r++) begin
      n = 0;
      p = divided_clock_pin;
      while (divided_clock_pin === p && n < 400) begin
        @(negedge clk);
        n++;
      end
    end
    check_val(8'(n), 8'(e));
  endtask : half

  initial begin
    int cdfs [3] = '{1, 5, 12};
    logic [7:0] v;
    int n;
    void'($urandom(63));
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n <= 1'b1;
    repeat (2) @(negedge clk);
    check_val(8'(internalClockRun), 8'h01);
    half(12);
    for (int m = 0; m < 4; m++) begin
      set_mode({2'(m), 6'h1E}, 8'h43);
      check_val(8'(ep2IsoMode), 8'(m));
    end
    check_val(8'(dplus_pullup_enable), 8'h01);
    foreach (cdfs[i]) begin
      set_mode(8'h1E, 8'h40 | 8'(cdfs[i]));
      half(cdfs[i] + 1);
    end
    set_mode(8'h1E, 8'h4F);
    repeat (30) @(negedge clk);
    check_val(8'(divided_clock_pin), 8'h00);
    set_mode(8'h18, 8'h43);
    host.set_susp(1'b1);
    half(CLK_HZ / (2 * SUSPEND_CLK_HZ) + 1);
    check_val(8'(internalClockRun), 8'h00);
    @(negedge clk);
    vbusPresent <= 1'b0;
    repeat (2) @(negedge clk);
    check_val(8'(dplus_pullup_enable), 8'h00);
    vbusPresent <= 1'b1;
    host.set_susp(1'b0);
    cmd(CMD_READ_IRQ);
    rd(8'h80);
    drain();
    host.bus_reset();
    cmd(CMD_READ_IRQ);
    rd(8'h40);
    cmd(CMD_READ_IRQ);
    rd(8'h00);
    drain();
    check_val(8'(dplus_pullup_enable), 8'h01);
    half(4);
    host.send('{4'h2, 1'b1, ERR_NONE, 1'b0, 1'b1});
    host.send('{4'h2, 1'b1, ERR_NONE, 1'b0, 1'b1});
    cmd(CMD_READ_IRQ);
    rd(8'h04);
    cmd(8'h42);
    rd(8'hC1);
    cmd(CMD_READ_IRQ);
    rd(8'h00);
    for (int c = 0; c < 16; c++)
      if (c != 7 && c != 12 && c != 14) begin
        drain();
        host.send('{4'h0, 1'b0, ucs_err_t'(c), 1'b1, 1'b0});
        cmd(8'h40);
        rd({3'b001, 4'(c), 1'b0});
      end
    set_mode(8'h10, 8'h43);
    host.send('{4'h1, 1'b0, ERR_NAKED, 1'b0, 1'b0});
    @(negedge clk);
    check_val(8'(irqPin), 8'h00);
    cmd(CMD_READ_IRQ);
    rd(8'h00);
    cmd(8'h41);
    rd(8'h12);
    drain();
    bufFull0 <= 16'($urandom);
    bufFull1 <= 16'($urandom);
    epStalled <= 16'($urandom);
    epSetup <= 16'($urandom);
    for (int e = 0; e < 6; e++) begin
      cmd(8'(e));
      rd({6'h00, epStalled[e], bufFull0[e] | bufFull1[e]});
      v = {epStalled[e], bufFull1[e], bufFull0[e], 2'b00, epSetup[e], 2'b00};
      cmd(8'h80 | 8'(e));
      rd(v);
    end
    cmd(8'h07);
    drain();
    check_val(8'(selectedEp), 8'h05);
    enhancedMode <= 1'b1;
    set_mode(8'hD8, 8'h43);
    check_val(8'(ep2IsoMode), 8'h00);
    for (int k = 0; k < 16; k++) begin
      v = 8'($urandom) & 8'h7F;
      cmd(8'hB0 | 8'(k));
      put(WK_WDATA, v);
      repeat (3) @(negedge clk);
      check_val(endpoint_setup_byte[k], v);
    end
    cmd(8'h0A);
    repeat (3) @(negedge clk);
    check_val(8'(selectedEp), 8'h0A);
    host.send('{4'h9, 1'b1, ERR_NONE, 1'b0, 1'b0});
    host.send('{4'hF, 1'b1, ERR_NONE, 1'b0, 1'b0});
    check_val(8'(irqPin), 8'h01);
    cmd(CMD_READ_IRQ);
    rd(8'h00);
    cmd(CMD_READ_IRQ);
    rd(8'h00);
    rd(8'h00);
    rd(8'h08);
    rd(8'h02);
    drain();
    set_mode(8'hD8, 8'hC3);
    check_val(8'(irqPin), 8'h00);
    host.sof();
    check_val(8'(irqPin), 8'h01);
    @(negedge clk);
    check_val(8'(irqPin), 8'h00);
    @(posedge clk);
    rdRandom = 1'b0;
    cmd(CMD_READ_IRQ);
    rd(8'h00);
    n = 0;
    @(negedge clk);
    cmdWord <= '{WK_WDATA, 8'h00};
    cmdValid <= 1'b1;
    do begin
      @(posedge clk);
      n += int'(cmdReady === 1'b1);
    end while (cmdReady === 1'b1 && n < 40);
    @(negedge clk);
    cmdValid <= 1'b0;
    check_val(8'(n >= FIFO_DEPTH && n < 36), 8'h01);
    @(posedge clk);
    rdRandom = 1'b1;
    drain();
    wrap_up();
  end
endmodule : usb_device_command_status_regs_bench
